// ### scc_map.svh
// named constants for the card clock and fault shutdown block
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

`define SCC_CLK_MHZ      125
`define SCC_OVL_US       100
`define SCC_STEP_US      10
`define SCC_DEACT_MAX_US 100
`define SCC_PUMP_KHZ     2500
`define SCC_DIV_W        3

`define SCC_PIN_W        6
`define SCC_PIN_OSC      0
`define SCC_PIN_SEL_A    1
`define SCC_PIN_SEL_B    2
`define SCC_PIN_SUPPLY   3
`define SCC_PIN_OVL      4
`define SCC_PIN_ACT      5

`endif

// ### scc_pkg.sv
// types shared by the card clock and fault shutdown block
package scc_pkg;

  // encoding is {select_a, select_b} as seen on the pins
  typedef enum logic [1:0] {
    SCC_DIV8 = 2'h0,
    SCC_DIV4 = 2'h1,
    SCC_DIV1 = 2'h2,
    SCC_DIV2 = 2'h3
  } scc_div_t;

  typedef enum logic [2:0] {
    SCC_IDLE    = 3'h0,
    SCC_ACTIVE  = 3'h1,
    SCC_D_RST   = 3'h2,
    SCC_D_CLK   = 3'h3,
    SCC_D_DATA  = 3'h4,
    SCC_D_VCC   = 3'h5,
    SCC_D_BOOST = 3'h6
  } scc_state_t;

  typedef struct packed {
    logic boost_en;
    logic vcc_en;
    logic data_en;
    logic clk_run;
    logic rst;
  } scc_card_t;

endpackage : scc_pkg

// ### scc_clkdiv.sv
// card clock divider with glitch-free ratio and run changes
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_clkdiv
  import scc_pkg::*;
#(
  parameter int CNT_W = `SCC_DIV_W
) (
  input  wire logic     clk,
  input  wire logic     rstn,
  input  wire logic     ce,
  input  wire logic     osc,
  input  wire scc_div_t sel,
  input  wire logic     run,
  output logic          card_clk
);

  if (CNT_W != `SCC_DIV_W) begin : g_bad_width
    $error("scc_clkdiv: counter must be 3 bits for divide by 8");
  end

  logic             osc_q;
  logic [CNT_W-1:0] cnt;
  scc_div_t         sel_q;
  logic             run_q;
  logic             src;
  logic             rise;
  logic             fall;
  logic             boundary;

  assign rise     = osc & ~osc_q;
  assign fall     = ~osc & osc_q;
  // every divided clock and the oscillator are low here
  assign boundary = fall && (cnt == '0); // [RL11]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_q <= 1'b0;
    end else if (ce) begin
      osc_q <= osc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= '0;
    end else if (ce && rise) begin
      cnt <= cnt + 1'b1;
    end
  end

  // ratio and run take effect only at the common low point
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_q <= SCC_DIV8;
      run_q <= 1'b0;
    end else if (ce && boundary) begin // [RL2] [RL11]
      sel_q <= sel;
      run_q <= run;
    end
  end

  // counter bits toggle on oscillator rises, so each divided
  // clock has equal high and low time
  always_comb begin
    case (sel_q)
      SCC_DIV8: src = cnt[2]; // [RL1] [RL3]
      SCC_DIV4: src = cnt[1]; // [RL1] [RL3]
      SCC_DIV2: src = cnt[0]; // [RL1] [RL3]
      SCC_DIV1: src = osc;    // [RL1] [RL4]
      default:  src = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      card_clk <= 1'b0;
    end else if (ce) begin
      card_clk <= run_q & src;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  chk_ratio_apply: assert property ( // [RL11]
    (sel_q != $past(sel_q)) |-> $past(fall && (cnt == '0)))
    else $error("ratio applied away from common low point");

  chk_edge_cause: assert property ( // [RL2]
    $changed(card_clk) |-> ($past(rise || fall) || $past(rise || fall, 2)))
    else $error("card clock edge without oscillator edge");

  cov_ratio_change: cover property ($changed(sel_q) && run_q);

endmodule : scc_clkdiv

`default_nettype wire

// ### scc_top.sv
// card clock generation, supply hold-off and fault deactivation
//
// Behaviour
// [RL1] select pins choose divide by 8/4/2/1
// [RL2] ratio changes produce no short pulses
// [RL3] card clock high time within 45-55%
// [RL4] crystal or external clock on oscillator input
// [RL5] hold logic until supply ok; secure on drop
// [RL6] overload starts deactivation without host request
// [RL7] overload deactivation begins by 250 us
// [RL8] own 2.5 MHz converter clock
// [RL9] rst, clock, lines, vcc, boost off in order
// [RL10] any fault drives fault alert low; only a fault in the active state sets it here
// [RL11] new ratio applied where all clocks low
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_top
  import scc_pkg::*;
#(
  parameter int OVL_CYC       = `SCC_OVL_US * `SCC_CLK_MHZ,
  parameter int DEACT_MAX_CYC = `SCC_DEACT_MAX_US * `SCC_CLK_MHZ
) (
  input  wire logic CLK_SYS,
  input  wire logic RSTN,
  input  wire logic CE,
  input  wire logic OSCILLATOR_INPUT,
  input  wire logic CLOCK_DIVIDE_SELECT_A,
  input  wire logic CLOCK_DIVIDE_SELECT_B,
  input  wire logic SUPPLY_OK,
  input  wire logic OVERLOAD,
  input  wire logic ACTIVATE,
  output logic      CARD_CLK,
  output logic      CARD_RST,
  output logic      LINES_LOW,
  output logic      CARD_SUPPLY_EN,
  output logic      BOOSTED_SUPPLY_EN,
  output logic      PUMP_CLK,
  output logic      FAULT_ALERT_N_O,
  output logic      FAULT_ALERT_N_OEN
);

  localparam int STEP_CYC  = `SCC_STEP_US * `SCC_CLK_MHZ;
  localparam int PUMP_HALF = (`SCC_CLK_MHZ * 1000) / (2 * `SCC_PUMP_KHZ);
  localparam int OVL_W     = $clog2(OVL_CYC + 1);
  localparam int STEP_W    = $clog2(STEP_CYC + 1);
  localparam int DEACT_W   = $clog2(DEACT_MAX_CYC + 1);
  localparam int PUMP_W    = $clog2(PUMP_HALF + 1);

  if (OVL_CYC < 1 || 5 * STEP_CYC > DEACT_MAX_CYC) begin : g_bad_timing
    $error("scc_top: overload filter or deactivation budget invalid");
  end

  logic [`SCC_PIN_W-1:0] pin_raw;
  logic [`SCC_PIN_W-1:0] pin_s1;
  logic [`SCC_PIN_W-1:0] pin_s2;
  logic                  supply_ok;
  logic                  ovl;
  logic                  act;
  logic                  ovl_trip;
  logic                  fault;
  logic                  step_done;
  logic                  alert_n;
  logic                  card_clk;
  logic [OVL_W-1:0]      ovl_cnt;
  logic [STEP_W-1:0]     step_cnt;
  logic [DEACT_W-1:0]    deact_cyc;
  logic [PUMP_W-1:0]     pump_cnt;
  scc_state_t            state;
  scc_state_t            next_state;
  scc_card_t             card;

  assign pin_raw[`SCC_PIN_OSC]    = OSCILLATOR_INPUT;
  assign pin_raw[`SCC_PIN_SEL_A]  = CLOCK_DIVIDE_SELECT_A;
  assign pin_raw[`SCC_PIN_SEL_B]  = CLOCK_DIVIDE_SELECT_B;
  assign pin_raw[`SCC_PIN_SUPPLY] = SUPPLY_OK;
  assign pin_raw[`SCC_PIN_OVL]    = OVERLOAD;
  assign pin_raw[`SCC_PIN_ACT]    = ACTIVATE;

  // every pin is asynchronous to the system clock
  for (genvar i = 0; i < `SCC_PIN_W; i++) begin : g_sync
    always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
        pin_s1[i] <= 1'b0;
        pin_s2[i] <= 1'b0;
      end else if (CE) begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
      end
    end
  end

  assign supply_ok = pin_s2[`SCC_PIN_SUPPLY];
  assign ovl       = pin_s2[`SCC_PIN_OVL];
  assign act       = pin_s2[`SCC_PIN_ACT];

  // oscillator is sampled, so inputs above ~62 MHz (half the system clock) alias
  scc_clkdiv u_clkdiv (
    .clk      (CLK_SYS),
    .rstn     (RSTN),
    .ce       (CE),
    .osc      (pin_s2[`SCC_PIN_OSC]), // [RL4]
    .sel      (scc_div_t'({pin_s2[`SCC_PIN_SEL_A],
                           pin_s2[`SCC_PIN_SEL_B]})), // [RL1]
    .run      (card.clk_run),
    .card_clk (card_clk)
  );

  // short current spikes are filtered; only a lasting overload trips
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ovl_cnt <= '0;
    end else if (CE) begin
      if (state == SCC_ACTIVE && ovl && !ovl_trip) begin
        ovl_cnt <= ovl_cnt + 1'b1; // [RL7]
      end else begin
        ovl_cnt <= '0;
      end
    end
  end

  assign ovl_trip  = ovl && (ovl_cnt == OVL_W'(OVL_CYC - 1)); // [RL7]
  assign fault     = ovl_trip || !supply_ok; // [RL5] [RL6]
  assign step_done = (step_cnt == STEP_W'(STEP_CYC - 1));

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      step_cnt <= '0;
    end else if (CE) begin
      if (next_state != state || state == SCC_IDLE ||
          state == SCC_ACTIVE) begin
        step_cnt <= '0;
      end else begin
        step_cnt <= step_cnt + 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      SCC_IDLE: begin
        if (supply_ok && act && alert_n) begin // [RL5]
          next_state = SCC_ACTIVE;
        end
      end
      SCC_ACTIVE: begin
        if (fault || !act) begin // [RL6] [RL10]
          next_state = SCC_D_RST;
        end
      end
      SCC_D_RST: begin
        if (step_done) begin // [RL9]
          next_state = SCC_D_CLK;
        end
      end
      SCC_D_CLK: begin
        if (step_done) begin // [RL9]
          next_state = SCC_D_DATA;
        end
      end
      SCC_D_DATA: begin
        if (step_done) begin // [RL9]
          next_state = SCC_D_VCC;
        end
      end
      SCC_D_VCC: begin
        if (step_done) begin // [RL9]
          next_state = SCC_D_BOOST;
        end
      end
      SCC_D_BOOST: begin
        if (step_done) begin
          next_state = SCC_IDLE;
        end
      end
      default: next_state = SCC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state <= SCC_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // card controls follow the state; all come on together, and one drops per deactivation step
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      card <= '0;
    end else if (CE) begin
      case (next_state)
        SCC_ACTIVE:  card <= 5'h1f;
        SCC_D_RST:   card <= 5'h1e; // [RL9]
        SCC_D_CLK:   card <= 5'h1c; // [RL9]
        SCC_D_DATA:  card <= 5'h18; // [RL9]
        SCC_D_VCC:   card <= 5'h10; // [RL9]
        default:     card <= 5'h00; // [RL9]
      endcase
    end
  end

  // alert holds until the host withdraws its request after shutdown;
  // a fault in the clearing cycle does not keep it set, as only the active state sets it
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      alert_n <= 1'b1;
    end else if (CE) begin
      if (state == SCC_ACTIVE && fault) begin
        alert_n <= 1'b0; // [RL10]
      end else if (state == SCC_IDLE && !act) begin
        alert_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      deact_cyc <= '0;
    end else if (CE) begin
      if (state == SCC_IDLE || state == SCC_ACTIVE) begin
        deact_cyc <= '0;
      end else begin
        deact_cyc <= deact_cyc + 1'b1;
      end
    end
  end

  // runs from the system clock while boost is enabled, never from the card clock
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pump_cnt <= '0;
      PUMP_CLK <= 1'b0;
    end else if (CE) begin
      if (!card.boost_en) begin
        pump_cnt <= '0;
        PUMP_CLK <= 1'b0;
      end else if (pump_cnt == PUMP_W'(PUMP_HALF - 1)) begin
        pump_cnt <= '0;
        PUMP_CLK <= ~PUMP_CLK; // [RL8]
      end else begin
        pump_cnt <= pump_cnt + 1'b1;
      end
    end
  end

  assign CARD_CLK          = card_clk;
  assign CARD_RST          = card.rst;
  assign LINES_LOW         = ~card.data_en;
  assign CARD_SUPPLY_EN    = card.vcc_en;
  assign BOOSTED_SUPPLY_EN = card.boost_en;
  assign FAULT_ALERT_N_O   = alert_n;
  assign FAULT_ALERT_N_OEN = alert_n;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN || !CE);

  chk_supply_hold: assert property ( // [RL5]
    state == SCC_IDLE && !supply_ok |=> state == SCC_IDLE)
    else $error("left idle while supply below threshold");

  chk_supply_secure: assert property ( // [RL5]
    state == SCC_ACTIVE && !supply_ok |=> state == SCC_D_RST ##1 !CARD_RST)
    else $error("supply drop did not secure the card");

  chk_ovl_trip: assert property ( // [RL6]
    state == SCC_ACTIVE && ovl && ovl_cnt == OVL_W'(OVL_CYC - 1)
    |=> state == SCC_D_RST && !FAULT_ALERT_N_OEN)
    else $error("overload did not start deactivation");

  chk_ovl_bound: assert property ( // [RL7]
    ovl_cnt <= OVL_W'(OVL_CYC - 1))
    else $error("overload filter overran its limit");

  chk_alert_fault: assert property ( // [RL10]
    $past(state == SCC_ACTIVE && fault) |-> !FAULT_ALERT_N_OEN
      && !FAULT_ALERT_N_O)
    else $error("fault without alert");

  chk_seq_order: assert property ( // [RL9]
    state == SCC_D_VCC |-> !card.rst && !card.clk_run && !card.data_en
      && !card.vcc_en && card.boost_en)
    else $error("deactivation steps out of order");

  chk_seq_total: assert property ( // [RL9]
    deact_cyc < DEACT_W'(DEACT_MAX_CYC))
    else $error("deactivation took too long");

  chk_pump_half: assert property ( // [RL8]
    $changed(PUMP_CLK) && $past(card.boost_en)
    |-> $past(pump_cnt) == PUMP_W'(PUMP_HALF - 1))
    else $error("converter clock half period wrong");

  cov_ovl_shutdown: cover property (
    state == SCC_ACTIVE && ovl_trip ##1 state == SCC_D_RST);
  cov_host_shutdown: cover property (
    state == SCC_D_BOOST && step_done ##1 state == SCC_IDLE);
  cov_session: cover property (state == SCC_IDLE ##1 state == SCC_ACTIVE);

endmodule : scc_top

`default_nettype wire

// ### scc_osc_model.sv
// free-running external oscillator model for the card clock input
`timescale 1ns/1ps
`default_nettype none

module scc_osc_model #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  output var logic  osc
);
  int cnt = 0;
  initial osc = 1'b0;
  // external clock on the first pin only, the crystal pin left open
  always @(posedge clk) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : scc_osc_model

`default_nettype wire

// ### scc_top_tb.sv
// self-checking bench for the card clock and fault shutdown block
`timescale 1ns/1ps
`default_nettype none

module scc_top_tb;
  import scc_pkg::*;
  localparam int OVL = 20;
  logic clk_sys, rstn, osc, sel_a, sel_b, sup, ovl, act;
  logic card_clk, card_rst, lines_low, vcc_en, boost_en, pump;
  logic alert_o, alert_oen;
  int   fail_count = 0;
  int   compares = 0;

  scc_osc_model #(.HALF(4)) i_scc_osc_model (.clk(clk_sys), .osc(osc));
  scc_top #(.OVL_CYC(OVL)) i_scc_top (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1),
    .OSCILLATOR_INPUT(osc), .CLOCK_DIVIDE_SELECT_A(sel_a),
    .CLOCK_DIVIDE_SELECT_B(sel_b), .SUPPLY_OK(sup), .OVERLOAD(ovl),
    .ACTIVATE(act), .CARD_CLK(card_clk), .CARD_RST(card_rst),
    .LINES_LOW(lines_low), .CARD_SUPPLY_EN(vcc_en),
    .BOOSTED_SUPPLY_EN(boost_en), .PUMP_CLK(pump),
    .FAULT_ALERT_N_O(alert_o), .FAULT_ALERT_N_OEN(alert_oen));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic activate();
    act = 1'b1;
    cyc(3);
    chk("session outs", 4'hb, {card_rst, lines_low, vcc_en, boost_en});
  endtask : activate

  task automatic t_reset();
    chk("reset outs", 7'h11, {card_clk, card_rst, lines_low, vcc_en,
        boost_en, pump, alert_oen});
    sup = 1'b0;
    act = 1'b1;
    cyc(30);
    chk("held without supply", 0, vcc_en);
    act = 1'b0;
    sup = 1'b1;
    cyc(5);
    $display("test reset done");
  endtask : t_reset

  // pump clock period taken between two rising edges
  task automatic t_pump();
    int i;
    activate();
    for (i = 0; i < 100 && pump !== 1'b0; i++) cyc(1);
    for (i = 0; i < 100 && pump !== 1'b1; i++) cyc(1);
    cyc(1);
    for (i = 1; i < 100 && pump !== 1'b0; i++) cyc(1);
    for (; i < 100 && pump !== 1'b1; i++) cyc(1);
    chk("pump period", 50, i);
    $display("test pump done");
  endtask : t_pump

  task automatic t_ratio();
    logic [1:0] sels [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int divs [4] = '{8, 4, 2, 1};
    int mn, run, hi, lo, i, k;
    logic prev, seen;
    for (k = 0; k < 4; k++) begin
      {sel_a, sel_b} = sels[k];
      mn = 99;
      run = 0;
      seen = 1'b0;
      prev = card_clk;
      repeat (200) begin
        cyc(1);
        if (card_clk !== prev) begin
          if (seen && run < mn) mn = run;
          seen = 1'b1;
          run = 0;
          prev = card_clk;
        end
        run++;
      end
      chk("shortest pulse ok", 1, mn >= 3);
      for (i = 0; i < 200 && card_clk !== 1'b0; i++) cyc(1);
      for (i = 0; i < 200 && card_clk !== 1'b1; i++) cyc(1);
      for (hi = 0; hi < 200 && card_clk === 1'b1; hi++) cyc(1);
      for (lo = 0; lo < 200 && card_clk === 1'b0; lo++) cyc(1);
      chk("card clk period", divs[k] * 8, hi + lo);
      chk("duty in range", 1, hi * 100 >= (hi + lo) * 45 &&
          hi * 100 <= (hi + lo) * 55);
    end
    $display("test ratio done");
  endtask : t_ratio

  // step times counted from the sample where card reset is first low
  task automatic t_deact(input logic exp_oen);
    int i, tl, tv, tb;
    logic clk_at;
    tl = 0;
    tv = 0;
    tb = 0;
    for (i = 0; i < 20000 && card_rst !== 1'b0; i++) cyc(1);
    chk("alert level", exp_oen, alert_oen);
    chk("alert data", exp_oen, alert_o);
    // run past the last step so the block is idle on return
    for (i = 0; i < 6300; i++) begin
      if (tl == 0 && lines_low === 1'b1) begin
        tl = i;
        clk_at = card_clk;
      end
      if (tv == 0 && vcc_en === 1'b0) tv = i;
      if (tb == 0 && boost_en === 1'b0) tb = i;
      cyc(1);
    end
    chk("lines low step", 2500, tl);
    chk("clock stopped first", 0, clk_at);
    chk("supply off step", 3750, tv);
    chk("boost off step", 5000, tb);
    chk("pump stopped", 0, pump);
  endtask : t_deact

  task automatic t_host_end();
    act = 1'b0;
    t_deact(1'b1);
    $display("test host end done");
  endtask : t_host_end

  task automatic t_overload();
    int n;
    activate();
    ovl = 1'b1;
    cyc(10);
    ovl = 1'b0;
    cyc(40);
    chk("short overload ignored", 1, card_rst);
    ovl = 1'b1;
    for (n = 0; n < 1000 && card_rst !== 1'b0; n++) cyc(1);
    chk("trip delay", 1, n >= OVL && n <= OVL + 5);
    t_deact(1'b0);
    ovl = 1'b0;
    cyc(20);
    chk("alert held, no restart", 2'h0, {alert_oen, vcc_en});
    act = 1'b0;
    cyc(10);
    chk("alert released", 1, alert_oen);
    $display("test overload done");
  endtask : t_overload

  task automatic t_supply_drop();
    activate();
    sup = 1'b0;
    t_deact(1'b0);
    sup = 1'b1;
    act = 1'b0;
    cyc(10);
    $display("test supply drop done");
  endtask : t_supply_drop

  initial begin
    rstn = 1'b0;
    {sel_a, sel_b, sup, ovl, act} = 5'h0;
    repeat (16) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    cyc(1);
    t_reset();
    t_pump();
    t_ratio();
    t_host_end();
    t_overload();
    t_supply_drop();
    wrap_up();
  end

  // runs well past the expected length of all tests
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
endmodule : scc_top_tb

`default_nettype wire
